// ==== slw_defines.vh ====
`ifndef SLW_DEFINES_VH
`define SLW_DEFINES_VH

// stop mode request codes
`define SLW_STOP_RUN    2'h0
`define SLW_STOP_LIGHT  2'h1
`define SLW_STOP_MIDDLE 2'h2
`define SLW_STOP_DEEP   2'h3

// power state codes
`define SLW_PWR_RUN     2'h0
`define SLW_PWR_LIGHT   2'h1
`define SLW_PWR_LOST    2'h2

// line path modes
`define SLW_PATH_DUPLEX 2'h0
`define SLW_PATH_LOOP   2'h1
`define SLW_PATH_SWIRE  2'h2

// reset values
`define SLW_RST_CFG     1'h0
`define SLW_RST_LINE    1'h1
`define SLW_RST_OE_B    1'h1

`endif

// ==== slw_pair_buf.v ====
`timescale 1ns/1ps
`include "slw_defines.vh"

// ------------------------------------------------------------
// two-entry buffer
// ------------------------------------------------------------
module slw_pair_buf #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         rst_b,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg  [W-1:0] mem_ff [0:1];
  reg          wr_ptr_ff;
  reg          rd_ptr_ff;
  reg  [1:0]   count_ff;
  wire         push;
  wire         pop;
  wire [1:0]   nxt_count;

  assign in_ready  = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign nxt_count = count_ff + {1'b0, push} - {1'b0, pop};

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mem_ff[0] <= {W{1'b0}};
      mem_ff[1] <= {W{1'b0}};
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= in_data;
        wr_ptr_ff         <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= nxt_count;
    end
  end

endmodule

// ==== slw_top.v ====
`timescale 1ns/1ps
`include "slw_defines.vh"

// ------------------------------------------------------------
// line routing, stop behaviour and receive edge detect
// ------------------------------------------------------------
module slw_top #(
  parameter SW = 2
) (
  input  wire          clock,
  input  wire          rst_b,
  input  wire [1:0]    stop_mode,
  input  wire          cfg_wr,
  input  wire          loop_select_enable,
  input  wire          receiver_source_select,
  input  wire          single_wire_direction,
  input  wire          rx_edge_irq_enable,
  input  wire          receiver_enable,
  input  wire          rx_edge_flag_clear,
  input  wire          tx_serial,
  input  wire          rxd_pin_in,
  input  wire          txd_pin_in,
  output reg           txd_pin_out_ff,
  output reg           txd_pin_oe_b_ff,
  output reg           rxd_pin_released_ff,
  output reg           rx_line_ff,
  output reg           rx_edge_flag_ff,
  output reg           wake_req_ff,
  output reg  [1:0]    path_mode_ff,
  output reg  [1:0]    pwr_state_ff,
  output wire          rx_sample_valid,
  input  wire          rx_sample_ready,
  output wire          rx_sample
);

  // ------------------------------------------------------------
  // power states
  // ------------------------------------------------------------
  localparam PWR_RUN   = `SLW_PWR_RUN;
  localparam PWR_LIGHT = `SLW_PWR_LIGHT;
  localparam PWR_LOST  = `SLW_PWR_LOST;

  function [1:0] path_of;
    input lse;
    input rss;
    begin
      if (!lse) begin
        path_of = `SLW_PATH_DUPLEX;
      end else if (!rss) begin
        path_of = `SLW_PATH_LOOP;
      end else begin
        path_of = `SLW_PATH_SWIRE;
      end
    end
  endfunction

  reg  [1:0]   nxt_pwr_state;
  wire         frozen;
  wire         cfg_lost;
  wire         detect_on;

  always @* begin
    nxt_pwr_state = pwr_state_ff;
    case (pwr_state_ff)
      PWR_RUN: begin
        if (stop_mode == `SLW_STOP_LIGHT) begin
          nxt_pwr_state = PWR_LIGHT;
        end else if (stop_mode != `SLW_STOP_RUN) begin
          nxt_pwr_state = PWR_LOST;
        end
      end
      PWR_LIGHT: begin
        if (stop_mode == `SLW_STOP_RUN) begin
          nxt_pwr_state = PWR_RUN;
        end else if (stop_mode != `SLW_STOP_LIGHT) begin
          nxt_pwr_state = PWR_LOST;
        end
      end
      PWR_LOST: begin
        if (stop_mode == `SLW_STOP_RUN) begin
          nxt_pwr_state = PWR_RUN;
        end
      end
      default: begin
        nxt_pwr_state = PWR_RUN;
      end
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwr_state_ff <= `SLW_PWR_RUN;
    end else begin
      pwr_state_ff <= nxt_pwr_state;
    end
  end

  // stop request acts in the same cycle so config writes, routing, line and buffer stop advancing once asked to stop
  assign frozen    = (stop_mode != `SLW_STOP_RUN);
  assign cfg_lost  = (stop_mode == `SLW_STOP_MIDDLE) |
                     (stop_mode == `SLW_STOP_DEEP);
  assign detect_on = (stop_mode == `SLW_STOP_RUN) |
                     (stop_mode == `SLW_STOP_LIGHT);

  // ------------------------------------------------------------
  // configuration bits
  // ------------------------------------------------------------
  reg lse_ff;
  reg rss_ff;
  reg dir_ff;
  reg irqen_ff;
  reg rxen_ff;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lse_ff   <= `SLW_RST_CFG;
      rss_ff   <= `SLW_RST_CFG;
      dir_ff   <= `SLW_RST_CFG;
      irqen_ff <= `SLW_RST_CFG;
      rxen_ff  <= `SLW_RST_CFG;
    end else if (cfg_lost) begin
      lse_ff   <= `SLW_RST_CFG;
      rss_ff   <= `SLW_RST_CFG;
      dir_ff   <= `SLW_RST_CFG;
      irqen_ff <= `SLW_RST_CFG;
      rxen_ff  <= `SLW_RST_CFG;
    end else if (cfg_wr & ~frozen) begin
      // light stop takes no writes and keeps every bit
      lse_ff   <= loop_select_enable;
      rss_ff   <= receiver_source_select;
      dir_ff   <= single_wire_direction;
      irqen_ff <= rx_edge_irq_enable;
      rxen_ff  <= receiver_enable;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [SW-1:0] rxd_sync_ff;
  reg [SW-1:0] txd_sync_ff;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxd_sync_ff <= {SW{`SLW_RST_LINE}};
      txd_sync_ff <= {SW{`SLW_RST_LINE}};
    end else begin
      rxd_sync_ff <= {rxd_sync_ff[SW-2:0], rxd_pin_in};
      txd_sync_ff <= {txd_sync_ff[SW-2:0], txd_pin_in};
    end
  end

  // ------------------------------------------------------------
  // line routing
  // ------------------------------------------------------------
  wire [1:0] path;
  reg        nxt_line;
  reg        nxt_pin_out;
  reg        nxt_oe_b;

  assign path = path_of(lse_ff, rss_ff);

  always @* begin
    nxt_line    = rxd_sync_ff[SW-1];
    nxt_pin_out = tx_serial;
    nxt_oe_b    = 1'b0;
    case (path)
      `SLW_PATH_DUPLEX: begin
        nxt_line = rxd_sync_ff[SW-1];
      end
      `SLW_PATH_LOOP: begin
        nxt_line = tx_serial;
      end
      `SLW_PATH_SWIRE: begin
        if (dir_ff) begin
          nxt_line = tx_serial;
          nxt_oe_b = 1'b0;
        end else begin
          // besides reset and the deeper stops, line is free for the far end only while we listen
          nxt_line = txd_sync_ff[SW-1];
          nxt_oe_b = 1'b1;
        end
      end
      default: begin
        nxt_line = rxd_sync_ff[SW-1];
      end
    endcase
  end

  // ------------------------------------------------------------
  // outputs and receive sample stream
  // ------------------------------------------------------------
  wire buf_in_ready;
  wire advance;
  reg  prev_line_ff;
  wire edge_seen;

  // a full buffer stalls sampling, so no sample is overwritten
  assign advance = ~frozen & buf_in_ready;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txd_pin_out_ff      <= `SLW_RST_LINE;
      txd_pin_oe_b_ff     <= `SLW_RST_OE_B;
      rxd_pin_released_ff <= `SLW_RST_CFG;
      rx_line_ff          <= `SLW_RST_LINE;
      path_mode_ff        <= `SLW_PATH_DUPLEX;
    end else if (cfg_lost) begin
      // deeper stops restart the path from idle
      txd_pin_out_ff      <= `SLW_RST_LINE;
      txd_pin_oe_b_ff     <= `SLW_RST_OE_B;
      rxd_pin_released_ff <= `SLW_RST_CFG;
      rx_line_ff          <= `SLW_RST_LINE;
      path_mode_ff        <= `SLW_PATH_DUPLEX;
    end else if (!frozen) begin
      // in light stop all of these hold and carry on afterwards
      txd_pin_out_ff      <= nxt_pin_out;
      txd_pin_oe_b_ff     <= nxt_oe_b;
      rxd_pin_released_ff <= lse_ff;
      path_mode_ff        <= path;
      if (advance) begin
        rx_line_ff <= nxt_line;
      end
    end
  end

  // ------------------------------------------------------------
  // receive edge detect and wake
  // ------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prev_line_ff <= `SLW_RST_LINE;
    end else if (!detect_on) begin
      prev_line_ff <= `SLW_RST_LINE;
    end else begin
      prev_line_ff <= nxt_line;
    end
  end

  // idle is high, so the active edge is a fall
  assign edge_seen = detect_on & rxen_ff & prev_line_ff & ~nxt_line;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_edge_flag_ff <= `SLW_RST_CFG;
      wake_req_ff     <= `SLW_RST_CFG;
    end else begin
      if (cfg_lost) begin
        rx_edge_flag_ff <= `SLW_RST_CFG;
      end else if (edge_seen) begin
        rx_edge_flag_ff <= 1'b1;
      end else if (rx_edge_flag_clear & ~frozen) begin
        rx_edge_flag_ff <= 1'b0;
      end
      if (pwr_state_ff == PWR_LIGHT && stop_mode == `SLW_STOP_LIGHT) begin
        wake_req_ff <= wake_req_ff | (edge_seen & irqen_ff);
      end else begin
        wake_req_ff <= 1'b0;
      end
    end
  end

  slw_pair_buf #(
    .W (1)
  ) u_buf (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (~frozen & rxen_ff),
    .in_ready  (buf_in_ready),
    .in_data   (nxt_line),
    .out_valid (rx_sample_valid),
    .out_ready (rx_sample_ready & ~frozen),
    .out_data  (rx_sample)
  );

endmodule

// ==== slw_far_dev.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// far device on the shared line
// ------------------------------------------------------------
module slw_far_dev (
  input  wire clock,
  input  wire rst_b,
  input  wire line_oe_b,
  input  wire talk,
  output reg  far_low_ff
);
  // pulls low only while the line is released, pull-up otherwise
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      far_low_ff <= 1'h0;
    end else begin
      far_low_ff <= talk & line_oe_b;
    end
  end
endmodule

// ==== slw_top_assertions.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module slw_chk #(
  parameter SW = 2
) (
  input  wire       clock,
  input  wire       rst_b,
  input  wire [1:0] stop_mode,
  input  wire       cfg_wr,
  input  wire       loop_select_enable,
  input  wire       receiver_source_select,
  input  wire       single_wire_direction,
  input  wire       receiver_enable,
  input  wire       rx_edge_flag_clear,
  input  wire       tx_serial,
  input  wire       rx_sample_ready,
  input  wire       txd_pin_out_ff,
  input  wire       txd_pin_oe_b_ff,
  input  wire       rxd_pin_released_ff,
  input  wire       rx_line_ff,
  input  wire       rx_edge_flag_ff,
  input  wire       wake_req_ff,
  input  wire [1:0] path_mode_ff,
  input  wire [1:0] pwr_state_ff
);
  reg re_cfg_ff;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // mirror of the receiver enable, lost in the deep stops
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) re_cfg_ff <= 1'h0;
    else if (stop_mode[1]) re_cfg_ff <= 1'h0;
    else if (cfg_wr && stop_mode == 2'h0) re_cfg_ff <= receiver_enable;
  end
  sequence s_quiet;
    (!cfg_wr && stop_mode == 2'h0)[*3];
  endsequence
  sequence s_wr(l, r);
    cfg_wr && stop_mode == 2'h0 && loop_select_enable == l && receiver_source_select == r;
  endsequence
  a_path_duplex: assert property (s_wr(0, 0) ##1 s_quiet |-> path_mode_ff == 2'h0 &&
    !rxd_pin_released_ff && !txd_pin_oe_b_ff) else $error("duplex routing wrong");
  a_path_loop: assert property (s_wr(1, 0) ##1 s_quiet |-> path_mode_ff == 2'h1 &&
    rxd_pin_released_ff) else $error("loop routing wrong");
  a_path_swire: assert property (s_wr(1, 1) ##1 s_quiet |-> path_mode_ff == 2'h2 &&
    txd_pin_oe_b_ff == !$past(single_wire_direction, 3)) else $error("single wire dir wrong");
  a_tx_drive: assert property (!txd_pin_oe_b_ff && stop_mode == 2'h0 ##1 !txd_pin_oe_b_ff
    |-> txd_pin_out_ff == $past(tx_serial)) else $error("pin not following transmitter");
  a_loop_feed: assert property (rx_sample_ready[*3] ##0 path_mode_ff == 2'h1 &&
    stop_mode == 2'h0 |=> rx_line_ff == $past(tx_serial)) else $error("loop feed wrong");
  a_edge_set: assert property ($fell(rx_line_ff) && stop_mode == 2'h0 && re_cfg_ff ##1
    (!rx_edge_flag_clear && stop_mode == 2'h0)[*2] |-> rx_edge_flag_ff) else $error("no edge flag");
  a_flag_clear: assert property (rx_edge_flag_clear && stop_mode == 2'h0 && !re_cfg_ff
    |=> !rx_edge_flag_ff) else $error("edge flag not cleared");
  a_deep_lost: assert property (stop_mode[1] ##1 stop_mode[1] |-> path_mode_ff == 2'h0 &&
    pwr_state_ff == 2'h2 && !rx_edge_flag_ff && txd_pin_oe_b_ff) else $error("state kept");
  a_light_freeze: assert property (stop_mode == 2'h1 ##1 stop_mode == 2'h1 |->
    $stable(path_mode_ff) && $stable(rx_line_ff) && $stable(txd_pin_out_ff)) else $error("moved");
  a_wake_drop: assert property (stop_mode != 2'h1 |=> !wake_req_ff)
    else $error("wake outside light stop");
endmodule
bind slw_top slw_chk #(.SW(SW)) u_chk (.*);

// ==== slw_top_bench.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module slw_top_bench;
  reg        clock, rst_b, cfg_wr, lse, rss, dir, irq, re, clr, tx, rxd, talk, rdy;
  reg  [1:0] stop;
  wire       pin_out, oe_b, rel, line, flag, wake, far_low, s_valid, s_data;
  wire [1:0] path, pwr;
  wire       txd_wire = oe_b ? ~far_low : pin_out;
  integer    fails, samples_checked, m;
  slw_top dut (.clock(clock), .rst_b(rst_b), .stop_mode(stop), .cfg_wr(cfg_wr),
    .loop_select_enable(lse), .receiver_source_select(rss), .single_wire_direction(dir),
    .rx_edge_irq_enable(irq), .receiver_enable(re), .rx_edge_flag_clear(clr),
    .tx_serial(tx), .rxd_pin_in(rxd), .txd_pin_in(txd_wire), .txd_pin_out_ff(pin_out),
    .txd_pin_oe_b_ff(oe_b), .rxd_pin_released_ff(rel), .rx_line_ff(line),
    .rx_edge_flag_ff(flag), .wake_req_ff(wake), .path_mode_ff(path), .pwr_state_ff(pwr),
    .rx_sample_valid(s_valid), .rx_sample_ready(rdy), .rx_sample(s_data));
  slw_far_dev far (.clock(clock), .rst_b(rst_b), .line_oe_b(oe_b), .talk(talk),
    .far_low_ff(far_low));
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  // bits: loop, source, direction, irq enable, receiver enable
  task cfg(input [4:0] v);
    begin
      @(posedge clock);
      {lse, rss, dir, irq, re} <= v;
      cfg_wr <= 1'h1;
      @(posedge clock) cfg_wr <= 1'h0;
      cyc(3);
    end
  endtask
  task check(input [3:0] got, input [3:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // whole run is under two hundred cycles; this leaves wide margin
  initial begin
    #20000;
    fails = fails + 1;
    stop_test;
  end
  initial begin
    fails = 0;
    samples_checked = 0;
    {rst_b, cfg_wr, lse, rss, dir, irq, re, clr, talk} = 9'h000;
    {tx, rxd, rdy} = 3'h7;
    stop = 2'h0;
    cyc(20);
    check({oe_b, rel}, 2'h2);
    check({line, flag}, 2'h2);
    @(posedge clock) rst_b <= 1'h1;
    cfg(5'h01);
    check({path, oe_b, rel}, 2'h0);
    @(posedge clock) tx <= 1'h0;
    cyc(3);
    check({pin_out, line}, 2'h1);
    @(posedge clock) rxd <= 1'h0;
    cyc(6);
    check({line, flag}, 2'h1);
    @(posedge clock) clr <= 1'h1;
    @(posedge clock) clr <= 1'h0;
    cyc(1);
    check(flag, 1'h0);
    @(posedge clock) rdy <= 1'h0;
    cyc(6);
    check({s_valid, s_data}, 2'h2);
    @(posedge clock) rxd <= 1'h1;
    cyc(6);
    check(line, 1'h0);
    @(posedge clock) rdy <= 1'h1;
    cfg(5'h00);
    cyc(3);
    check({s_valid, line, flag}, 2'h2);
    $display("duplex test done");
    cfg(5'h11);
    check({path, rel}, 3'h3);
    cyc(3);
    check(line, 1'h0);
    @(posedge clock) tx <= 1'h1;
    cyc(3);
    check(line, 1'h1);
    cfg(5'h1d);
    check({path, oe_b, rel}, 4'h9);
    @(posedge clock) tx <= 1'h0;
    cyc(3);
    check({pin_out, line}, 2'h0);
    @(posedge clock) tx <= 1'h1;
    cfg(5'h19);
    check({oe_b, rel}, 2'h3);
    @(posedge clock) talk <= 1'h1;
    cyc(6);
    check(line, 1'h0);
    @(posedge clock) talk <= 1'h0;
    cyc(6);
    $display("loop test done");
    // receiver off: a clear must still drop the flag left by the loop test
    cfg(5'h02);
    @(posedge clock) clr <= 1'h1;
    @(posedge clock) clr <= 1'h0;
    cyc(1);
    check(flag, 1'h0);
    cfg(5'h03);
    // stop is only asked for while the line is idle
    @(posedge clock) stop <= 2'h1;
    cyc(2);
    check(pwr, 2'h1);
    @(posedge clock) rxd <= 1'h0;
    cyc(6);
    check({wake, line}, 2'h3);
    cfg(5'h11);
    @(posedge clock) stop <= 2'h0;
    cyc(2);
    check({wake, path, oe_b}, 4'h0);
    cyc(3);
    check(line, 1'h0);
    cfg(5'h01);
    @(posedge clock) rxd <= 1'h1;
    cyc(4);
    @(posedge clock) stop <= 2'h1;
    rxd <= 1'h0;
    cyc(6);
    check(wake, 1'h0);
    $display("light stop test done");
    for (m = 2; m < 4; m = m + 1) begin
      stop <= 2'h0;
      rxd <= 1'h1;
      cfg(5'h1d);
      @(posedge clock) stop <= m[1:0];
      rxd <= 1'h0;
      cyc(5);
      check({pwr, flag, wake}, 4'h8);
      @(posedge clock) stop <= 2'h0;
      cyc(3);
      check({path, oe_b, rel}, 4'h0);
    end
    $display("deep stop test done");
    stop_test;
  end
endmodule
